// ---- testbench.sv ----
// self-checking bench for the mode-change serial port
`timescale 1ns/1ps
`include "umc_regs.vh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, err_q;
	logic [7:0] paddr, b;
	logic [31:0] pwdata, rd_q, m_n, e_n;
	logic [31:0] exp_q[$], msk_q[$];
	wire [31:0] prdata;
	wire pready, pslverr, txd, irq, rxd;
	int n_fail, samples_checked;
	umc_uart u_umc_uart (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
	umc_line_model u_line (.pclk(pclk), .txd(txd), .rxd(rxd));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; a read notes its expectation for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
		begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			n_fail++;
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0000_0000);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, e, m);
	endtask
	// read status until the masked field matches, bounded
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 200; i++)
		begin
			rd(`UMC_OFF_STATUS, 32'h0000_0000, 32'h0000_0000);
			if ((rd_q & m) === v)
				return;
		end
		n_fail++;
		final_report();
	endtask
	// take the oldest note whenever a read completes and compare unless its mask is zero
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
		begin
			m_n = msk_q.pop_front();
			e_n = exp_q.pop_front();
			if (m_n !== 32'h0000_0000)
				chk(prdata & m_n, e_n);
		end
	initial
	begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		void'($urandom(32'h5b8c_8dda));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`UMC_OFF_MODE, 32'h0000_0007, 32'h0000_0007);
		rd(`UMC_OFF_DIV, 32'h0000_ffff, 32'h0000_0001);
		rd(8'h20, 32'hffff_ffff, 32'h0000_0000);
		chk({31'h0, err_q}, 32'h0000_0001);
		wr(`UMC_OFF_INTMASK, 32'h0000_0001);
		// plain mode through the safe sequence, one looped byte
		wr(`UMC_OFF_MODE, {29'h0, `UMC_MODE_UART});
		poll(32'h0002_0000, 32'h0000_0000);
		wr(`UMC_OFF_FIFOCTL, 32'h0000_0003);
		b = 8'($urandom);
		wr(`UMC_OFF_DATA, {24'h0, b});
		poll(32'h0000_1f00, 32'h0000_0100);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(`UMC_OFF_DATA, 32'h0000_00ff, {24'h0, b});
		rd(`UMC_OFF_INTSTAT, 32'h0000_0001, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0000_0000);
		// clears zero the occupancy counts
		repeat (3) wr(`UMC_OFF_DATA, $urandom & 32'h0000_00ff);
		wr(`UMC_OFF_FIFOCTL, 32'h0000_0002);
		rd(`UMC_OFF_STATUS, 32'h0000_001f, 32'h0000_0000);
		poll(32'h000c_0000, 32'h0000_0000);
		wr(`UMC_OFF_FIFOCTL, 32'h0000_0001);
		rd(`UMC_OFF_STATUS, 32'h0000_1f00, 32'h0000_0000);
		// infrared: halted until the resume read
		wr(`UMC_OFF_MODE, {29'h0, `UMC_MODE_IRDA});
		poll(32'h0002_0000, 32'h0000_0000);
		wr(`UMC_OFF_FIFOCTL, 32'h0000_0003);
		rd(`UMC_OFF_STATUS, 32'h0001_0000, 32'h0001_0000);
		b = 8'($urandom);
		wr(`UMC_OFF_DATA, {24'h0, b});
		repeat (40) @(posedge pclk);
		rd(`UMC_OFF_STATUS, 32'h0004_001f, 32'h0000_0001);
		rd(`UMC_OFF_RESUME, 32'hffff_ffff, 32'h0000_0000);
		poll(32'h0000_1f00, 32'h0000_0100);
		rd(`UMC_OFF_DATA, 32'h0000_00ff, {24'h0, b});
		// back to plain, then a mode access in mid-frame drops the frame
		wr(`UMC_OFF_MODE, {29'h0, `UMC_MODE_UART});
		poll(32'h0002_0000, 32'h0000_0000);
		wr(`UMC_OFF_FIFOCTL, 32'h0000_0003);
		rd(`UMC_OFF_RESUME, 32'hffff_ffff, 32'h0000_0000);
		wr(`UMC_OFF_DATA, $urandom & 32'h0000_00ff);
		repeat (30) @(posedge pclk);
		rd(`UMC_OFF_MODE, 32'h0000_0007, 32'h0000_0000);
		repeat (300) @(posedge pclk);
		rd(`UMC_OFF_STATUS, 32'h000c_1f1f, 32'h0000_0000);
		final_report();
	end
endmodule

// ---- umc_checker.sv ----
// assertion checker for the mode-change serial port
`timescale 1ns/1ps
`include "umc_regs.vh"
module umc_checker (
	input wire pclk, // clock
	input wire presetn, // reset, active low
	input wire [7:0] paddr, // apb address
	input wire psel, // apb select
	input wire penable, // apb access
	input wire pwrite, // apb write
	input wire [31:0] pwdata, // apb write data
	input wire [31:0] prdata, // apb read data
	input wire pready, // apb ready
	input wire pslverr, // apb error
	input wire rxd, // receive pin
	input wire txd, // transmit pin
	input wire irq // interrupt
);
	wire done;
	wire rd_st;
	wire mapped;
	reg [2:0] mode_q;
	reg halt_q;
	reg txclr_q;
	reg [4:0] mask_q;
	assign done = psel && penable && pready;
	assign rd_st = done && !pwrite && paddr == `UMC_OFF_STATUS;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= `UMC_OFF_RESUME;
	// shadow of mode, halt, tx clear and mask, updated at completing edges
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= `UMC_MODE_RST;
			halt_q <= 1'b0;
			txclr_q <= 1'b0;
			mask_q <= `UMC_INT_RST;
		end
		else if (done)
		begin
			if (pwrite && paddr == `UMC_OFF_MODE)
				mode_q <= pwdata[2:0];
			if (paddr == `UMC_OFF_MODE && (mode_q == `UMC_MODE_IRDA
				|| (pwrite && pwdata[2:0] == `UMC_MODE_IRDA)))
				halt_q <= 1'b1;
			else if (!pwrite && paddr == `UMC_OFF_RESUME)
				halt_q <= 1'b0;
			if (pwrite && paddr == `UMC_OFF_FIFOCTL && pwdata[1])
				txclr_q <= 1'b1;
			else if (pwrite && paddr == `UMC_OFF_DATA)
				txclr_q <= 1'b0;
			if (pwrite && paddr == `UMC_OFF_INTMASK)
				mask_q <= pwdata[4:0];
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable ##1 psel && penable && !pready;
	endsequence
	property p_wait_one;
		s_setup |=> pready;
	endproperty
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_err;
		done |-> pslverr == !mapped;
	endproperty
	property p_halt;
		rd_st |-> prdata[16] == halt_q;
	endproperty
	property p_txclr;
		rd_st && txclr_q |-> prdata[4:0] == 5'h00;
	endproperty
	property p_irq_masked;
		(mask_q == 5'h00)[*2] |-> !irq;
	endproperty
	property p_txd_off;
		(mode_q == `UMC_MODE_OFF)[*2] |-> txd;
	endproperty
	property p_zero_regs;
		done && !pwrite && (paddr == `UMC_OFF_FIFOCTL || paddr == `UMC_OFF_RESUME)
			|-> prdata == 32'h0000_0000;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("ready not after one wait");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	a_err: assert property (p_err) else $error("error flag wrong for address");
	a_halt: assert property (p_halt) else $error("halt flag wrong");
	a_txclr: assert property (p_txclr) else $error("tx count not cleared");
	a_irq_masked: assert property (p_irq_masked) else $error("irq while all masked");
	a_txd_off: assert property (p_txd_off) else $error("txd low while off");
	a_zero_regs: assert property (p_zero_regs) else $error("control or resume read not 0");
endmodule

bind umc_uart umc_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

// ---- umc_fifo.v ----
// small byte fifo with a synchronous clear of its pointers and occupancy count
`timescale 1ns/1ps
`include "umc_regs.vh"

module umc_fifo (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire clr, // clear pointers and count
	input wire push, // write one byte
	input wire [`UMC_DATA_W-1:0] wdata, // byte to write
	input wire pop, // drop head byte
	output wire [`UMC_DATA_W-1:0] rdata, // head byte
	output wire [`UMC_FIFO_CW-1:0] count, // bytes held
	output wire full, // no room
	output wire empty // nothing held
);

	reg [`UMC_DATA_W-1:0] mem [0:`UMC_FIFO_DEPTH-1];
	reg [`UMC_FIFO_AW-1:0] wp_q;
	reg [`UMC_FIFO_AW-1:0] rp_q;
	reg [`UMC_FIFO_CW-1:0] cnt_q;
	wire do_push;
	wire do_pop;

	assign full = (cnt_q == `UMC_FIFO_DEPTH);
	assign empty = (cnt_q == {`UMC_FIFO_CW{1'b0}});
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;
	assign rdata = mem[rp_q];
	assign count = cnt_q;

	// storage array, written only when room remains
	always @(posedge pclk)
	begin
		if (do_push)
			mem[wp_q] <= wdata;
	end

	// pointers and occupancy; a clear empties the fifo outright
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wp_q <= {`UMC_FIFO_AW{1'b0}};
			rp_q <= {`UMC_FIFO_AW{1'b0}};
			cnt_q <= {`UMC_FIFO_CW{1'b0}};
		end
		else if (clr)
		begin
			wp_q <= {`UMC_FIFO_AW{1'b0}};
			rp_q <= {`UMC_FIFO_AW{1'b0}};
			cnt_q <= {`UMC_FIFO_CW{1'b0}};
		end
		else
		begin
			if (do_push)
				wp_q <= wp_q + 1'b1;
			if (do_pop)
				rp_q <= rp_q + 1'b1;
			if (do_push & ~do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop & ~do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

// ---- umc_line_model.sv ----
// looped transceiver facing the serial port pins
`timescale 1ns/1ps
module umc_line_model (
	input wire pclk, // clock
	input wire txd, // port transmit pin
	output logic rxd // port receive pin
);
	logic [1:0] dly_q;
	initial dly_q = 2'h3;
	initial rxd = 1'b1;
	// echo the transmit line after a short cable delay
	always @(posedge pclk)
	begin
		dly_q <= {dly_q[0], txd};
		rxd <= dly_q[1];
	end
endmodule

// ---- umc_regs.vh ----
// register map, field positions and timing counts of the mode-change serial port
`ifndef UMC_REGS_VH
`define UMC_REGS_VH

`define UMC_ADDR_W 8
`define UMC_OFF_DATA 8'h00
`define UMC_OFF_FIFOCTL 8'h04
`define UMC_OFF_MODE 8'h08
`define UMC_OFF_DIV 8'h0C
`define UMC_OFF_STATUS 8'h10
`define UMC_OFF_INTSTAT 8'h14
`define UMC_OFF_INTMASK 8'h18
`define UMC_OFF_RESUME 8'h1C

`define UMC_MODE_W 3
`define UMC_MODE_UART 3'h0
`define UMC_MODE_IRDA 3'h1
`define UMC_MODE_OFF 3'h7
`define UMC_MODE_RST 3'h7

`define UMC_FCR_RXCLR 0
`define UMC_FCR_TXCLR 1

`define UMC_DIV_W 16
`define UMC_DIV_RST 16'h0001

`define UMC_INT_W 5
`define UMC_INT_RX 0
`define UMC_INT_TXDONE 1
`define UMC_INT_HALT 2
`define UMC_INT_OVR 3
`define UMC_INT_FRAME 4
`define UMC_INT_RST 5'h00

`define UMC_ST_TXCNT 0
`define UMC_ST_RXCNT 8
`define UMC_ST_HALT 16
`define UMC_ST_SETTLE 17
`define UMC_ST_TXBUSY 18
`define UMC_ST_RXBUSY 19

`define UMC_FIFO_DEPTH 16
`define UMC_FIFO_AW 4
`define UMC_FIFO_CW 5
`define UMC_DATA_W 8

// settle wait after a mode write: 5 interconnect + 5 functional cycles, one clock here
`define UMC_SETTLE_IC 4'h5
`define UMC_SETTLE_FN 4'h5
`define UMC_SUB_LAST 4'hF
`define UMC_SUB_HALF 4'h7
`define UMC_IR_PULSE 4'h3
`define UMC_IR_STRETCH 5'h10
`define UMC_BIT_LAST 3'h7

`endif

// ---- umc_uart.v ----
// serial port with plain and infrared modes, apb registers and mode-change guard
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "umc_regs.vh"

module umc_uart (
	input wire pclk, // clock, 100 MHz
	input wire presetn, // async reset, active low
	input wire [`UMC_ADDR_W-1:0] paddr, // apb byte address
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb write
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	input wire rxd, // serial or infrared receive pin
	output reg txd, // serial or infrared transmit pin
	output reg irq // level interrupt
);

	localparam TX_IDLE = 2'b00;
	localparam TX_START = 2'b01;
	localparam TX_DATA = 2'b10;
	localparam TX_STOP = 2'b11;
	localparam RX_IDLE = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA = 2'b10;
	localparam RX_STOP = 2'b11;
	// address compare, used for every register
	function hit;
		input [`UMC_ADDR_W-1:0] a;
		input [`UMC_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction
	reg [`UMC_MODE_W-1:0] mode_q;
	reg [`UMC_DIV_W-1:0] div_q, div_cnt_q;
	reg [`UMC_INT_W-1:0] is_q, im_q, ev_c, is_d;
	reg [3:0] settle_q, tx_sub_q, rx_sub_q;
	reg rx_s1_q, rx_s2_q, rx_s3_q, rx_flt_q;
	reg [4:0] ir_str_q;
	reg [1:0] tx_st_q, rx_st_q;
	reg [2:0] tx_bit_q, rx_bit_q;
	reg [`UMC_DATA_W-1:0] tx_sh_q, rx_sh_q;
	reg [31:0] rdata_c;
	reg halt_q, txd_d, line_bit;
	wire [`UMC_DATA_W-1:0] txf_data, rxf_data;
	wire [`UMC_FIFO_CW-1:0] txf_cnt, rxf_cnt;
	wire txf_full, txf_empty, rxf_full, rxf_empty;
	wire acc_first = psel & penable & ~pready;
	wire acc_done = psel & penable & pready;
	wire wr = acc_done & pwrite & ~pslverr;
	wire rd = acc_done & ~pwrite & ~pslverr;
	wire mapped = hit(paddr, `UMC_OFF_DATA) | hit(paddr, `UMC_OFF_FIFOCTL) |
		hit(paddr, `UMC_OFF_MODE) | hit(paddr, `UMC_OFF_DIV) |
		hit(paddr, `UMC_OFF_STATUS) | hit(paddr, `UMC_OFF_INTSTAT) |
		hit(paddr, `UMC_OFF_INTMASK) | hit(paddr, `UMC_OFF_RESUME);
	wire mode_acc = acc_done & ~pslverr & hit(paddr, `UMC_OFF_MODE);
	wire mode_wr = mode_acc & pwrite;
	wire mode_ir = (mode_q == `UMC_MODE_IRDA);
	wire mode_on = (mode_q == `UMC_MODE_UART) | mode_ir;
	wire new_ir = mode_wr & (pwdata[`UMC_MODE_W-1:0] == `UMC_MODE_IRDA);
	wire settling = (settle_q != 4'h0);
	wire run = mode_on & ~settling;
	wire halt_set = mode_acc & (mode_ir | new_ir);
	wire abort = (mode_acc & ~mode_ir & ~new_ir) | ~run;
	wire resume_rd = rd & hit(paddr, `UMC_OFF_RESUME);
	wire tick = run & ((div_cnt_q + 1'b1) >= div_q); // divisor 0 acts as 1
	wire rx_line = mode_ir ? (ir_str_q == 5'h00) : rx_flt_q;
	wire txf_push = wr & hit(paddr, `UMC_OFF_DATA);
	wire txf_clr = wr & hit(paddr, `UMC_OFF_FIFOCTL) & pwdata[`UMC_FCR_TXCLR];
	wire rxf_clr = wr & hit(paddr, `UMC_OFF_FIFOCTL) & pwdata[`UMC_FCR_RXCLR];
	wire rxf_pop = rd & hit(paddr, `UMC_OFF_DATA);
	wire tx_go = (tx_st_q == TX_IDLE) & tick & ~halt_q & ~abort & ~txf_empty;
	wire rx_end = (rx_st_q == RX_STOP) & tick & (rx_sub_q == `UMC_SUB_LAST) & ~abort;
	wire rxf_push = rx_end & rx_line & ~rxf_full;

	// transmit fifo, filled by data writes, drained by the transmitter
	umc_fifo u_txf (
		.pclk(pclk), .presetn(presetn), .clr(txf_clr), .push(txf_push),
		.wdata(pwdata[`UMC_DATA_W-1:0]), .pop(tx_go), .rdata(txf_data),
		.count(txf_cnt), .full(txf_full), .empty(txf_empty)
	);
	// receive fifo, filled by the receiver, drained by data reads
	umc_fifo u_rxf (
		.pclk(pclk), .presetn(presetn), .clr(rxf_clr), .push(rxf_push),
		.wdata(rx_sh_q), .pop(rxf_pop), .rdata(rxf_data),
		.count(rxf_cnt), .full(rxf_full), .empty(rxf_empty)
	);

	// read data mux
	always @*
	begin
		rdata_c = 32'h0000_0000;
		if (hit(paddr, `UMC_OFF_DATA))
			rdata_c[`UMC_DATA_W-1:0] = rxf_empty ? 8'h00 : rxf_data;
		else if (hit(paddr, `UMC_OFF_MODE))
			rdata_c[`UMC_MODE_W-1:0] = mode_q;
		else if (hit(paddr, `UMC_OFF_DIV))
			rdata_c[`UMC_DIV_W-1:0] = div_q;
		else if (hit(paddr, `UMC_OFF_STATUS))
		begin
			rdata_c[`UMC_ST_TXCNT+`UMC_FIFO_CW-1:`UMC_ST_TXCNT] = txf_cnt;
			rdata_c[`UMC_ST_RXCNT+`UMC_FIFO_CW-1:`UMC_ST_RXCNT] = rxf_cnt;
			rdata_c[`UMC_ST_HALT] = halt_q;
			rdata_c[`UMC_ST_SETTLE] = settling;
			rdata_c[`UMC_ST_TXBUSY] = (tx_st_q != TX_IDLE);
			rdata_c[`UMC_ST_RXBUSY] = (rx_st_q != RX_IDLE);
		end
		else if (hit(paddr, `UMC_OFF_INTSTAT))
			rdata_c[`UMC_INT_W-1:0] = is_q;
		else if (hit(paddr, `UMC_OFF_INTMASK))
			rdata_c[`UMC_INT_W-1:0] = im_q;
	end

	// apb slave: one wait state so read data and ready come from flops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= acc_first;
			pslverr <= acc_first & ~mapped;
			if (acc_first)
				prdata <= mapped ? rdata_c : 32'h0000_0000;
		end
	end
	// interrupt events; a read clears only the bits it returned, new events win
	always @*
	begin
		ev_c = {`UMC_INT_W{1'b0}};
		ev_c[`UMC_INT_RX] = rxf_push;
		ev_c[`UMC_INT_TXDONE] = (tx_st_q == TX_STOP) & tick & (tx_sub_q == `UMC_SUB_LAST);
		ev_c[`UMC_INT_HALT] = halt_set;
		ev_c[`UMC_INT_OVR] = rx_end & rx_line & rxf_full;
		ev_c[`UMC_INT_FRAME] = rx_end & ~rx_line;
		is_d = is_q;
		if (rd & hit(paddr, `UMC_OFF_INTSTAT))
			is_d = is_q & ~prdata[`UMC_INT_W-1:0];
		is_d = is_d | ev_c;
	end
	// software registers, halt flag and settle counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q <= `UMC_MODE_RST;
			div_q <= `UMC_DIV_RST;
			is_q <= `UMC_INT_RST;
			im_q <= `UMC_INT_RST;
			halt_q <= 1'b0;
			settle_q <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			is_q <= is_d;
			irq <= |(is_d & im_q);
			if (mode_wr)
				mode_q <= pwdata[`UMC_MODE_W-1:0];
			if (wr & hit(paddr, `UMC_OFF_DIV))
				div_q <= pwdata[`UMC_DIV_W-1:0];
			if (wr & hit(paddr, `UMC_OFF_INTMASK))
				im_q <= pwdata[`UMC_INT_W-1:0];
			// mode access in infrared mode, or a write selecting it, freezes transmit until resume read
			if (halt_set)
				halt_q <= 1'b1;
			else if (resume_rd)
				halt_q <= 1'b0;
			// block holds its line logic idle while a new mode settles
			if (mode_wr)
				settle_q <= `UMC_SETTLE_IC + `UMC_SETTLE_FN;
			else if (settling)
				settle_q <= settle_q - 4'h1;
		end
	end
	// receive pin synchroniser and glitch filter, infrared pulse stretcher
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_flt_q <= 1'b1;
			ir_str_q <= 5'h00;
		end
		else
		begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q)
				rx_flt_q <= rx_s3_q;
			if (!run)
				ir_str_q <= 5'h00; // no stale pulse from the old mode's idle level
			else if (mode_ir & (rx_s2_q == rx_s3_q) & rx_s3_q)
				ir_str_q <= `UMC_IR_STRETCH;
			else if (tick & (ir_str_q != 5'h00))
				ir_str_q <= ir_str_q - 5'h01;
		end
	end
	// oversample divider, sixteen ticks per bit
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_q <= {`UMC_DIV_W{1'b0}};
		else if (!run | tick)
			div_cnt_q <= {`UMC_DIV_W{1'b0}};
		else
			div_cnt_q <= div_cnt_q + 1'b1;
	end
	// transmitter frame sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st_q <= TX_IDLE;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
		end
		else if (abort)
		begin
			tx_st_q <= TX_IDLE;
			tx_sub_q <= 4'h0;
		end
		else if (tx_go)
		begin
			tx_st_q <= TX_START;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_sh_q <= txf_data;
		end
		else if (tick & (tx_st_q != TX_IDLE))
		begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_sub_q == `UMC_SUB_LAST)
			begin
				case (tx_st_q)
				TX_START: tx_st_q <= TX_DATA;
				TX_DATA:
				begin
					tx_sh_q <= {1'b0, tx_sh_q[`UMC_DATA_W-1:1]};
					tx_bit_q <= tx_bit_q + 3'h1;
					if (tx_bit_q == `UMC_BIT_LAST)
						tx_st_q <= TX_STOP;
				end
				TX_STOP: tx_st_q <= TX_IDLE;
				default: tx_st_q <= TX_IDLE;
				endcase
			end
		end
	end
	// pin level: nrz in plain mode, 3/16 pulse per zero bit in infrared mode
	always @*
	begin
		case (tx_st_q)
		TX_START: line_bit = 1'b0;
		TX_DATA: line_bit = tx_sh_q[0];
		default: line_bit = 1'b1;
		endcase
		if (mode_ir)
			txd_d = ~line_bit & (tx_sub_q < `UMC_IR_PULSE);
		else
			txd_d = line_bit;
	end
	// pin register, so the pin level never glitches
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			txd <= 1'b1;
		else
			txd <= txd_d;
	end
	// receiver frame sequencer, samples mid-bit
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st_q <= RX_IDLE;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
		end
		else if (abort)
		begin
			rx_st_q <= RX_IDLE;
			rx_sub_q <= 4'h0;
		end
		else if (tick)
		begin
			rx_sub_q <= rx_sub_q + 4'h1;
			case (rx_st_q)
			RX_IDLE:
			begin
				rx_sub_q <= 4'h0;
				if (!rx_line)
					rx_st_q <= RX_START;
			end
			RX_START:
				if (rx_sub_q == `UMC_SUB_HALF)
				begin
					rx_sub_q <= 4'h0;
					rx_bit_q <= 3'h0;
					rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
				end
			RX_DATA:
				if (rx_sub_q == `UMC_SUB_LAST)
				begin
					rx_sh_q <= {rx_line, rx_sh_q[`UMC_DATA_W-1:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == `UMC_BIT_LAST)
						rx_st_q <= RX_STOP;
				end
			RX_STOP:
				if (rx_sub_q == `UMC_SUB_LAST)
					rx_st_q <= RX_IDLE;
			default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

endmodule
